// *** bench/pso_host_model.sv ***
// host model that writes and reads the slot selection registers
`default_nettype none

module pso_host_model (
   input wire logic clk_in,
   input wire logic [7:0] rdata_in,
   output logic wr_out = 1'b0,
   output logic rd_out = 1'b0,
   output logic [7:0] addr_out = 8'h00,
   output logic [7:0] wdata_out = 8'h00
);
   timeunit 1ns;
   timeprecision 1ps;

   ////////////////////////////////////////////////////////////////////////////
   // write strobe stays up so that writes can run back to back
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      rd_out = 1'b0;
      wr_out = 1'b1;
      addr_out = a;
      wdata_out = d;
      @(negedge clk_in);
   endtask

   // read data is taken once the taking edge has passed
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      wr_out = 1'b0;
      rd_out = 1'b1;
      addr_out = a;
      wdata_out = ~wdata_out;
      @(negedge clk_in);
      d = rdata_in;
   endtask

   // release the bus; lines scramble so stale values never look valid
   task automatic idle();
      wr_out = 1'b0;
      rd_out = 1'b0;
      addr_out = ~addr_out;
      wdata_out = ~wdata_out;
      @(negedge clk_in);
   endtask
endmodule

`default_nettype wire

// *** bench/tb.sv ***
// self-checking bench for the slot on/off selection bank
`default_nettype none

module tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [7:0] G2 = 8'ha5;
   localparam logic [7:0] G3 = 8'h3c;
   localparam logic [7:0] G4 = 8'h0f;
   logic clk_in = 1'b0;
   logic rst_n_in = 1'b0;
   logic wr, rd, tick;
   logic [7:0] addr, wdata, rdata, rdata_b;
   logic [1:0] mode = 2'b00;
   logic [2:0] dur = 3'h0;
   logic [7:0] fade = 8'h5a;
   pso_pkg::pso_slot_s st;
   int n_fail = 0;
   int comparisons = 0;

   ////////////////////////////////////////////////////////////////////////////
   // clock, parts under test and host
   initial begin
      forever #12.5 clk_in = ~clk_in;
   end

   pso_slot_onoff #(.CYC_PER_MS(1), .BREATHE_DEFAULT(1'b1)) DUT (
      .clk_in(clk_in), .rst_n_in(rst_n_in), .reg_wr_in(wr), .reg_rd_in(rd),
      .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_rdata_out(rdata),
      .sequencer_slot_count_in(mode), .slot_duration_select_in(dur),
      .slot_fade_choice_in(fade), .slot_state_out(st), .slot_tick_out(tick));

   pso_slot_onoff #(.CYC_PER_MS(1), .BREATHE_DEFAULT(1'b0)) DUT_b (
      .clk_in(clk_in), .rst_n_in(rst_n_in), .reg_wr_in(wr), .reg_rd_in(rd),
      .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_rdata_out(rdata_b),
      .sequencer_slot_count_in(mode), .slot_duration_select_in(dur),
      .slot_fade_choice_in(fade), .slot_state_out(), .slot_tick_out());

   pso_host_model host (.clk_in(clk_in), .rdata_in(rdata), .wr_out(wr), .rd_out(rd),
      .addr_out(addr), .wdata_out(wdata));

   ////////////////////////////////////////////////////////////////////////////
   // checking helpers
   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      comparisons++;
      if (g !== e) begin
         n_fail++;
         $display("[FAIL] %s exp %0h got %0h", nm, e, g);
      end
   endtask

   function automatic logic [7:0] exp_st(input logic [2:0] k);
      return {1'b1, k, G4[k], G3[k], G2[k], fade[k]};
   endfunction

   task automatic tally_and_finish();
      if (n_fail == 0 && comparisons > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // scenarios
   task automatic t_reset();
      logic [7:0] v;
      for (logic [7:0] a = 8'h12; a <= 8'h14; a++) begin
         host.rd(a, v);
         chk("reset_breathe", 16'(pso_pkg::PSO_RST_BREATHE), 16'(v));
         chk("reset_off", 16'(pso_pkg::PSO_RST_DISABLED), 16'(rdata_b));
      end
      host.idle();
   endtask

   task automatic t_regs();
      logic [7:0] v;
      host.wr(pso_pkg::PSO_OFF_GROUP2, G2);
      host.wr(pso_pkg::PSO_OFF_GROUP3, G3);
      host.wr(pso_pkg::PSO_OFF_GROUP4, G4);
      host.wr(8'h11, 8'hff);
      host.rd(pso_pkg::PSO_OFF_GROUP2, v);
      chk("group2", 16'(G2), 16'(v));
      host.rd(pso_pkg::PSO_OFF_GROUP3, v);
      chk("group3", 16'(G3), 16'(v));
      host.rd(pso_pkg::PSO_OFF_GROUP4, v);
      chk("group4", 16'(G4), 16'(v));
      host.rd(8'h11, v);
      chk("unmapped", 16'(pso_pkg::PSO_UNMAPPED_DATA), 16'(v));
      host.idle();
   endtask

   task automatic t_seq(input logic [1:0] m, input logic [2:0] s, input int last);
      int n;
      mode = m;
      dur = s;
      @(negedge clk_in);
      chk("slot_first", 16'(exp_st(3'h0)), 16'(st));
      for (int i = 1; i <= last + 1; i++) begin
         n = 0;
         do begin
            @(negedge clk_in);
            n++;
         end while (tick !== 1'b1 && n < 2100);
         chk("slot_state", 16'(exp_st(3'(i % (last + 1)))), 16'(st));
         chk("slot_tick", 16'h0001, 16'(tick));
         // the first slot started one cycle before the counting loop began
         chk("slot_len", 16'(pso_pkg::PSO_SLOT_MS[s] - ((i == 1) ? 1 : 0)), 16'(n));
      end
      mode = 2'b00;
      @(negedge clk_in);
      @(negedge clk_in);
      chk("mode_off", 16'h0000, 16'(st));
   endtask

   // reset in mid-run must bring written registers back to their reset values
   task automatic t_midreset();
      logic [7:0] v;
      host.rd(pso_pkg::PSO_OFF_GROUP3, v);
      chk("group3_kept", 16'(G3), 16'(v));
      rst_n_in = 1'b0;
      host.idle();
      chk("reset_rdata", 16'(pso_pkg::PSO_UNMAPPED_DATA), 16'(rdata));
      rst_n_in = 1'b1;
      t_reset();
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // main sequence and watchdog
   initial begin
      repeat (12) @(negedge clk_in);
      rst_n_in = 1'b1;
      t_reset();
      t_regs();
      t_seq(2'b01, 3'h0, 3);
      t_seq(2'b10, 3'h1, 5);
      t_seq(2'b11, 3'h7, 7);
      t_midreset();
      tally_and_finish();
   end

   initial begin
      #1000000;
      n_fail++;
      tally_and_finish();
   end
endmodule

`default_nettype wire

// *** common/pso_pkg.sv ***
// shared constants and types for the pattern slot on/off selection bank
`default_nettype none

package pso_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // register map
   localparam int unsigned PSO_GROUPS = 3;
   localparam int unsigned PSO_SLOTS = 8;
   localparam int unsigned PSO_DATA_W = 8;
   localparam int unsigned PSO_ADDR_W = 8;
   localparam logic [7:0] PSO_OFF_GROUP2 = 8'h12;
   localparam logic [7:0] PSO_OFF_GROUP3 = 8'h13;
   localparam logic [7:0] PSO_OFF_GROUP4 = 8'h14;
   localparam logic [7:0] PSO_UNMAPPED_DATA = 8'h00;

   // reset values: slots 3..7 always clear, slots 0..2 follow the variant
   localparam logic [7:0] PSO_RST_DISABLED = 8'h00;
   localparam logic [7:0] PSO_RST_BREATHE = 8'h07;
   localparam int unsigned PSO_VARIANT_MSB = 2;
   localparam logic [4:0] PSO_RST_UPPER = 5'h00;

   ////////////////////////////////////////////////////////////////////////////
   // sequencer modes
   typedef enum logic [1:0] {
      PSO_MODE_OFF = 2'b00,
      PSO_MODE_4 = 2'b01,
      PSO_MODE_6 = 2'b10,
      PSO_MODE_8 = 2'b11
   } pso_mode_e;

   localparam logic [2:0] PSO_LAST_4 = 3'h3;
   localparam logic [2:0] PSO_LAST_6 = 3'h5;
   localparam logic [2:0] PSO_LAST_8 = 3'h7;
   localparam logic [2:0] PSO_SLOT_FIRST = 3'h0;

   ////////////////////////////////////////////////////////////////////////////
   // slot timing: durations in ms, counts derived from the clock rate
   localparam int unsigned PSO_SLOT_MS [8] = '{188, 250, 375, 500, 750, 1000, 1500, 2000};
   localparam int unsigned PSO_CLK_HZ = 40000000;
   localparam int unsigned PSO_CYC_PER_MS = PSO_CLK_HZ / 1000;
   localparam int unsigned PSO_CNT_W = 27;

   ////////////////////////////////////////////////////////////////////////////
   // per-cycle view of the running pattern
   typedef struct packed {
      logic active;
      logic [2:0] slot;
      logic [2:0] group_on;
      logic fade_sel;
   } pso_slot_s;

endpackage

`default_nettype wire

// *** design/pso_slot_onoff.sv ***
// on/off selection registers for RGB groups 2..4 and the slot sequencer
//
// Summary of operation
// - register 0x12 holds group 2 on/off choice, one bit per slot.
// - register 0x13 holds group 3 on/off choice, one bit per slot.
// - register 0x14 holds group 4 on/off choice, one bit per slot.
// - a clear bit in the active slot fades the group down, then off.
// - a set bit in the active slot turns the group on, then fades up.
// - slot bits 3 to 7 reset to zero in every variant.
// - slot bits 0 to 2 reset to zero, or one on breathing variants.
// - every bit is host writable and reads back its last written value.
// - mode 00 stops the sequencer; 01, 10, 11 run 4, 6, 8 slots.
// - each slot lasts a 3-bit selected time from 188 ms to 2 s.
// - a per-slot bit picks fade rate setting 0 or 1 for that slot.
`default_nettype none

module pso_slot_onoff #(
   parameter int unsigned CYC_PER_MS = pso_pkg::PSO_CYC_PER_MS,
   parameter bit BREATHE_DEFAULT = 1'b0
) (
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire logic reg_wr_in,
   input wire logic reg_rd_in,
   input wire logic [7:0] reg_addr_in,
   input wire logic [7:0] reg_wdata_in,
   output logic [7:0] reg_rdata_out,
   input wire logic [1:0] sequencer_slot_count_in,
   input wire logic [2:0] slot_duration_select_in,
   input wire logic [7:0] slot_fade_choice_in,
   output pso_pkg::pso_slot_s slot_state_out,
   output logic slot_tick_out
);

   localparam logic [7:0] RST_VAL = BREATHE_DEFAULT ? pso_pkg::PSO_RST_BREATHE
                                                    : pso_pkg::PSO_RST_DISABLED;

   logic [7:0] onoff_q [pso_pkg::PSO_GROUPS];
   logic [pso_pkg::PSO_GROUPS-1:0] hit;
   logic [pso_pkg::PSO_GROUPS-1:0] sel_now;
   logic [7:0] rdata_d;
   logic [7:0] rdata_q;
   logic [2:0] slot_q;
   logic [2:0] slot_d;
   logic [2:0] last_slot;
   logic enabled;
   logic tick;
   logic tick_q;
   pso_pkg::pso_mode_e mode;
   pso_pkg::pso_slot_s state_d;
   pso_pkg::pso_slot_s state_q;

   ////////////////////////////////////////////////////////////////////////////
   // address decode, one selection register per group
   assign hit[0] = (reg_addr_in == pso_pkg::PSO_OFF_GROUP2);
   assign hit[1] = (reg_addr_in == pso_pkg::PSO_OFF_GROUP3);
   assign hit[2] = (reg_addr_in == pso_pkg::PSO_OFF_GROUP4);

   // read mux: mapped registers return their contents, anything else zero
   assign rdata_d = hit[0] ? onoff_q[0] :
                    hit[1] ? onoff_q[1] :
                    hit[2] ? onoff_q[2] : pso_pkg::PSO_UNMAPPED_DATA;

   ////////////////////////////////////////////////////////////////////////////
   // storage and per-group slot selection
   for (genvar g = 0; g < pso_pkg::PSO_GROUPS; g++) begin : g_group
      // variant reset value, host writes replace the whole byte
      always_ff @(posedge clk_in or negedge rst_n_in) begin
         if (!rst_n_in) begin
            onoff_q[g] <= RST_VAL;
         end else if (reg_wr_in && hit[g]) begin
            onoff_q[g] <= reg_wdata_in;
         end
      end
      // bit of the slot being entered decides the group's direction
      assign sel_now[g] = onoff_q[g][slot_d];
   end

   // read data is held until the next read
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         rdata_q <= pso_pkg::PSO_UNMAPPED_DATA;
      end else if (reg_rd_in) begin
         rdata_q <= rdata_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // mode decode: off leaves the groups to software
   assign mode = pso_pkg::pso_mode_e'(sequencer_slot_count_in);
   assign enabled = (mode != pso_pkg::PSO_MODE_OFF);

   always_comb begin
      unique case (mode)
         pso_pkg::PSO_MODE_4: last_slot = pso_pkg::PSO_LAST_4;
         pso_pkg::PSO_MODE_6: last_slot = pso_pkg::PSO_LAST_6;
         pso_pkg::PSO_MODE_8: last_slot = pso_pkg::PSO_LAST_8;
         pso_pkg::PSO_MODE_OFF: last_slot = pso_pkg::PSO_SLOT_FIRST;
      endcase
   end

   // slot duration timer
   pso_slot_timer #(
      .CYC_PER_MS(CYC_PER_MS),
      .CNT_W(pso_pkg::PSO_CNT_W)
   ) u_timer (
      .clk_in(clk_in),
      .rst_n_in(rst_n_in),
      .run_in(enabled),
      .sel_in(slot_duration_select_in),
      .tick_out(tick)
   );

   ////////////////////////////////////////////////////////////////////////////
   // slot stepping; >= also folds back a slot left high by a mode change
   assign slot_d = !enabled ? pso_pkg::PSO_SLOT_FIRST :
                   !tick ? slot_q :
                   (slot_q >= last_slot) ? pso_pkg::PSO_SLOT_FIRST : slot_q + 3'h1;

   // state shown to the fade engines
   assign state_d.active = enabled;
   assign state_d.slot = slot_d;
   assign state_d.group_on = enabled ? sel_now : 3'h0;
   assign state_d.fade_sel = enabled && slot_fade_choice_in[slot_d];

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         slot_q <= pso_pkg::PSO_SLOT_FIRST;
         state_q <= '0;
         tick_q <= 1'b0;
      end else begin
         slot_q <= slot_d;
         state_q <= state_d;
         tick_q <= tick;
      end
   end

   assign reg_rdata_out = rdata_q;
   assign slot_state_out = state_q;
   assign slot_tick_out = tick_q;

   ////////////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!rst_n_in);

   a_group2_write: assert property (reg_wr_in && hit[0] |=> onoff_q[0] == $past(reg_wdata_in))
      else $error("group 2 register did not take the write");
   a_group3_write: assert property (reg_wr_in && hit[1] |=> onoff_q[1] == $past(reg_wdata_in))
      else $error("group 3 register did not take the write");
   a_group4_write: assert property (reg_wr_in && hit[2] |=> onoff_q[2] == $past(reg_wdata_in))
      else $error("group 4 register did not take the write");

   a_off_when_clear: assert property (enabled && !sel_now[0] |=> !state_q.group_on[0])
      else $error("group 2 on although its slot bit is clear");
   a_on_when_set: assert property (enabled && sel_now[2] |=> state_q.group_on[2])
      else $error("group 4 off although its slot bit is set");

   sequence s_reset_release;
      !rst_n_in ##1 rst_n_in;
   endsequence
   a_reset_upper: assert property (@(posedge clk_in) disable iff (1'b0)
      s_reset_release |-> onoff_q[1][7:3] == pso_pkg::PSO_RST_UPPER)
      else $error("upper slot bits not clear after reset");
   a_reset_variant: assert property (@(posedge clk_in) disable iff (1'b0)
      s_reset_release |-> onoff_q[0][2:0] == RST_VAL[2:0])
      else $error("lower slot bits wrong after reset");

   a_read_back: assert property (reg_rd_in && hit[1] && !reg_wr_in |=> reg_rdata_out == onoff_q[1])
      else $error("read of group 3 register returned the wrong value");

   a_mode_off: assert property (!enabled |=> !state_q.active && state_q.group_on == 3'h0)
      else $error("sequencer active while mode is off");
   a_four_slot_range: assert property (mode == pso_pkg::PSO_MODE_4 && slot_q <= 3'h3
                                       |=> slot_q <= 3'h3)
      else $error("four slot mode left slots 0 to 3");

   a_fade_choice: assert property (enabled && slot_fade_choice_in[slot_d]
                                   |=> state_q.fade_sel)
      else $error("fade rate choice not passed on");

   sequence s_step_tick;
      enabled && tick && slot_q < last_slot;
   endsequence
   a_slot_ascend: assert property (s_step_tick |=> slot_q == $past(slot_q) + 3'h1 ##1 tick_q == 1'b0)
      else $error("slot did not step up by one");
   a_slot_wrap: assert property (enabled && tick && slot_q >= last_slot |=> slot_q == 3'h0)
      else $error("slot did not wrap to zero");

endmodule

`default_nettype wire

// *** design/pso_slot_timer.sv ***
// slot duration timer producing one pulse at the end of each pattern slot
`default_nettype none

module pso_slot_timer #(
   parameter int unsigned CYC_PER_MS = pso_pkg::PSO_CYC_PER_MS,
   parameter int unsigned CNT_W = pso_pkg::PSO_CNT_W
) (
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire logic run_in,
   input wire logic [2:0] sel_in,
   output logic tick_out
);

   logic [CNT_W-1:0] cnt_q;
   logic [CNT_W-1:0] cnt_d;
   logic [CNT_W-1:0] term;
   logic [31:0] term_full;

   ////////////////////////////////////////////////////////////////////////////
   // last count of the selected duration; >= so a shorter choice ends at once
   assign term_full = pso_pkg::PSO_SLOT_MS[sel_in] * CYC_PER_MS - 32'd1;
   assign term = term_full[CNT_W-1:0];
   assign tick_out = run_in && (cnt_q >= term);
   assign cnt_d = (!run_in || tick_out) ? '0 : cnt_q + {{(CNT_W-1){1'b0}}, 1'b1};

   // counter restarts whenever the sequencer is off
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         cnt_q <= '0;
      end else begin
         cnt_q <= cnt_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!rst_n_in);

   a_tick_restart: assert property (tick_out |=> cnt_q == '0)
      else $error("slot timer did not restart after its tick");
   a_count_advance: assert property (run_in && !tick_out |=> cnt_q == $past(cnt_q) + 1'b1)
      else $error("slot timer failed to advance");

endmodule

`default_nettype wire
